// ---- src/mcds_pkg.sv ----
// Constants and types shared by the calibration debug status block
// Notes on behaviour
// - Run power-up init after reset before calibration
// - Init programs each mode register by commands
// - No calibration failure reported during init
// - Done flag low until calibration succeeds
// - Nine-bit status word before calibration
// - Per-rank 128-bit calibration stage status bus
// - Nine-bit status word after calibration
// - Status readable at any time
// - Mode registers zero to six split 9/7
// - Clock period split as 9/8 bits
// - Module type codes 01 to 04
// - Supply level codes 01 to 03
// - Memory family codes 01 to 04
// - Transmit PLL multiply and divide words
// - Clock manager multiply and divide words
// - Config words 0-32, name, info reserved
// - Extended debug set only when option enabled
package mcds_pkg;
   // Word indices on the debug read port
   localparam logic [5:0] IDX_CFG_FIRST   = 6'h00; // Reserved config words 0..32
   localparam logic [5:0] IDX_CFG_LAST    = 6'h20;
   localparam logic [5:0] IDX_MR_BASE     = 6'h21; // Mode reg low/high pairs
   localparam logic [5:0] IDX_CODE_NAME   = 6'h2f; // Reserved
   localparam logic [5:0] IDX_PERIOD_LO   = 6'h30;
   localparam logic [5:0] IDX_PERIOD_HI   = 6'h31;
   localparam logic [5:0] IDX_MOD_TYPE    = 6'h32;
   localparam logic [5:0] IDX_VOLTAGE     = 6'h33;
   localparam logic [5:0] IDX_MEM_FAMILY  = 6'h34;
   localparam logic [5:0] IDX_PLL_MULT    = 6'h35;
   localparam logic [5:0] IDX_PLL_DIV     = 6'h36;
   localparam logic [5:0] IDX_CM_MULT     = 6'h37;
   localparam logic [5:0] IDX_CM_DIV      = 6'h38;
   localparam logic [5:0] IDX_CTRL_INFO   = 6'h39; // Reserved
   localparam logic [5:0] IDX_PRE_STATUS  = 6'h3a;
   localparam logic [5:0] IDX_POST_STATUS = 6'h3b;
   localparam logic [5:0] IDX_DONE        = 6'h3c;
   // Field layout
   localparam int MR_LO_W     = 9;
   localparam int MR_HI_W     = 7;
   localparam int PER_LO_W    = 9;
   localparam int PER_HI_W    = 8;
   localparam int NUM_MR      = 7;
   localparam int STAT_W      = 9;
   localparam int RANK_STAT_W = 128;
   // Encodings
   localparam logic [7:0] MOD_COMPONENT = 8'h01;
   localparam logic [7:0] MOD_UDIMM     = 8'h02;
   localparam logic [7:0] MOD_SODIMM    = 8'h03;
   localparam logic [7:0] MOD_RDIMM     = 8'h04;
   localparam logic [7:0] VOLT_1V20     = 8'h01;
   localparam logic [7:0] VOLT_1V35     = 8'h02;
   localparam logic [7:0] VOLT_1V50     = 8'h03;
   localparam logic [7:0] FAM_DDR3      = 8'h01;
   localparam logic [7:0] FAM_DDR4      = 8'h02;
   localparam logic [7:0] FAM_RLDRAM    = 8'h03;
   localparam logic [7:0] FAM_QDRSRAM   = 8'h04;
   // Reset values
   localparam logic [15:0] RD_RESET     = 16'h0000;
   localparam logic [15:0] RESERVED_VAL = 16'h0000;
   // Status bits of pre/post words
   localparam int PRE_INIT_DONE_BIT = 0;
   localparam int PRE_MRS_DONE_BIT  = 1;
   localparam int POST_FAIL_BIT     = 0;
   // Init sequencer timing
   localparam int  INIT_WAIT_NS  = 500;  // Settle time before first mode command
   localparam int  CLK_PERIOD_NS = 4;
   localparam int  INIT_WAIT_CYC = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  MRS_GAP_CYC   = 4;    // Spacing between mode register commands
   // Sequencer states
   typedef enum logic [2:0] {
      MCDS_RESET, MCDS_INIT_WAIT, MCDS_MRS, MCDS_CAL, MCDS_DONE, MCDS_FAIL
   } mcds_state_t;
endpackage : mcds_pkg

// ---- src/mcds_status.sv ----
// Calibration debug status bank: init sequencer, status capture, read port
`timescale 1ns/1ps
`default_nettype none
module mcds_status #(
   parameter int          NUM_RANKS   = 1,
   parameter bit          DEBUG_EXT   = 1'b0,
   parameter logic [15:0] MR_VAL0     = 16'h0000,
   parameter logic [15:0] MR_VAL1     = 16'h0000,
   parameter logic [15:0] MR_VAL2     = 16'h0000,
   parameter logic [15:0] MR_VAL3     = 16'h0000,
   parameter logic [15:0] MR_VAL4     = 16'h0000,
   parameter logic [15:0] MR_VAL5     = 16'h0000,
   parameter logic [15:0] MR_VAL6     = 16'h0000,
   parameter logic [16:0] CLK_PERIOD  = 17'h00000,
   parameter logic [7:0]  MODULE_TYPE = 8'h01,
   parameter logic [7:0]  VOLTAGE     = 8'h01,
   parameter logic [7:0]  MEM_FAMILY  = 8'h02,
   parameter logic [15:0] PLL_MULT    = 16'h0001,
   parameter logic [15:0] PLL_DIV     = 16'h0001,
   parameter logic [15:0] CM_MULT     = 16'h0001,
   parameter logic [15:0] CM_DIV      = 16'h0001
) (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst_b,
   // Calibration engine handshake
   input  wire logic                          cal_pass,
   input  wire logic                          cal_fail,
   input  wire logic [NUM_RANKS*128-1:0]      rank_stage_in,
   // Mode register command issue
   output logic                               mrs_valid,
   output logic [2:0]                         mrs_sel,
   output logic [15:0]                        mrs_value,
   output logic                               cal_start,
   // Status outputs
   output logic                               calib_done,
   output logic [8:0]                         pre_status,
   output logic [8:0]                         post_status,
   output logic [NUM_RANKS*128-1:0]           rank_status,
   // Extended debug probe
   output logic [2:0]                         dbg_state,
   // Debug host read port
   input  wire logic                          dbg_rd,
   input  wire logic                          dbg_wr,
   input  wire logic [5:0]                    dbg_addr,
   input  wire logic [15:0]                   dbg_wdata,
   output logic [15:0]                        dbg_rdata,
   output logic                               dbg_ack
);
   // Elaboration checks on parameters
   if (NUM_RANKS < 1 || NUM_RANKS > 4) begin : g_bad_ranks
      $error("NUM_RANKS must lie in 1..4");
   end
   if (mcds_pkg::INIT_WAIT_CYC < 1) begin : g_bad_wait
      $error("Init wait must be at least one cycle");
   end
   if (mcds_pkg::MRS_GAP_CYC < 2) begin : g_bad_gap
      $error("Mode command gap must be at least two cycles");
   end

   // Table of mode register values indexed by number
   logic [15:0] mr_tab [mcds_pkg::NUM_MR];
   assign mr_tab[0] = MR_VAL0;
   assign mr_tab[1] = MR_VAL1;
   assign mr_tab[2] = MR_VAL2;
   assign mr_tab[3] = MR_VAL3;
   assign mr_tab[4] = MR_VAL4;
   assign mr_tab[5] = MR_VAL5;
   assign mr_tab[6] = MR_VAL6;

   // Sequencer state and counters
   mcds_pkg::mcds_state_t state_r;       // Current phase
   logic [15:0]           wait_cnt_r;    // Settle and gap counter
   logic [2:0]            mr_idx_r;      // Next mode register to program
   logic [15:0]           mr_shadow_r [mcds_pkg::NUM_MR]; // Values actually issued

   // Phase sequencer: init wait, mode programming, then calibration
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r    <= mcds_pkg::MCDS_RESET;
         wait_cnt_r <= 16'h0000;
         mr_idx_r   <= 3'h0;
      end else begin
         case (state_r)
            mcds_pkg::MCDS_RESET: begin
               // Reset just released: begin power-up init
               state_r    <= mcds_pkg::MCDS_INIT_WAIT;
               wait_cnt_r <= 16'(mcds_pkg::INIT_WAIT_CYC - 1);
            end
            mcds_pkg::MCDS_INIT_WAIT: begin
               if (wait_cnt_r == 16'h0000) begin
                  // First command leaves here, so its gap starts one short
                  state_r    <= mcds_pkg::MCDS_MRS;
                  wait_cnt_r <= 16'(mcds_pkg::MRS_GAP_CYC - 2);
               end else begin
                  wait_cnt_r <= wait_cnt_r - 16'h0001;
               end
            end
            mcds_pkg::MCDS_MRS: begin
               // One command per gap, all seven registers
               if (wait_cnt_r != 16'h0000) begin
                  wait_cnt_r <= wait_cnt_r - 16'h0001;
               end else if (mr_idx_r == 3'(mcds_pkg::NUM_MR - 1)) begin
                  state_r <= mcds_pkg::MCDS_CAL; // Calibration only after init
               end else begin
                  mr_idx_r   <= mr_idx_r + 3'h1;
                  wait_cnt_r <= 16'(mcds_pkg::MRS_GAP_CYC - 1);
               end
            end
            mcds_pkg::MCDS_CAL: begin
               // Failure only seen here, never during init
               if (cal_fail) begin
                  state_r <= mcds_pkg::MCDS_FAIL;
               end else if (cal_pass) begin
                  state_r <= mcds_pkg::MCDS_DONE;
               end
            end
            mcds_pkg::MCDS_DONE: state_r <= mcds_pkg::MCDS_DONE;
            mcds_pkg::MCDS_FAIL: state_r <= mcds_pkg::MCDS_FAIL;
            default:             state_r <= mcds_pkg::MCDS_RESET;
         endcase
      end
   end

   // Mode command issue: pulse on the first cycle of each gap
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mrs_valid <= 1'b0;
         mrs_sel   <= 3'h0;
         mrs_value <= 16'h0000;
      end else begin
         mrs_valid <= 1'b0;
         if (state_r == mcds_pkg::MCDS_MRS && wait_cnt_r == 16'(mcds_pkg::MRS_GAP_CYC - 1)
             || state_r == mcds_pkg::MCDS_INIT_WAIT && wait_cnt_r == 16'h0000) begin
            mrs_valid <= 1'b1;
            mrs_sel   <= (state_r == mcds_pkg::MCDS_INIT_WAIT) ? 3'h0 : mr_idx_r;
            mrs_value <= mr_tab[(state_r == mcds_pkg::MCDS_INIT_WAIT) ? 3'h0 : mr_idx_r];
         end
      end
   end

   // Remember what was programmed so the read port reports it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < mcds_pkg::NUM_MR; i++) begin
            mr_shadow_r[i] <= 16'h0000;
         end
      end else if (mrs_valid) begin
         mr_shadow_r[mrs_sel] <= mrs_value;
      end
   end

   // Calibration start strobe and done flag
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cal_start  <= 1'b0;
         calib_done <= 1'b0;
      end else begin
         cal_start  <= (state_r == mcds_pkg::MCDS_MRS) && (wait_cnt_r == 16'h0000)
                       && (mr_idx_r == 3'(mcds_pkg::NUM_MR - 1));
         // High only after a pass, stays low on failure
         calib_done <= (state_r == mcds_pkg::MCDS_DONE)
                       || (state_r == mcds_pkg::MCDS_CAL && cal_pass && !cal_fail);
      end
   end

   // Pre and post status words and per-rank buses
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pre_status  <= 9'h000;
         post_status <= 9'h000;
         rank_status <= '0;
      end else begin
         // Core state before calibration
         pre_status[mcds_pkg::PRE_INIT_DONE_BIT] <= (state_r != mcds_pkg::MCDS_RESET)
                                                   && (state_r != mcds_pkg::MCDS_INIT_WAIT);
         pre_status[mcds_pkg::PRE_MRS_DONE_BIT]  <= (state_r == mcds_pkg::MCDS_CAL)
                                                   || (state_r == mcds_pkg::MCDS_DONE)
                                                   || (state_r == mcds_pkg::MCDS_FAIL);
         pre_status[8:2] <= 7'h00;
         // Per-rank stage status passes only once calibration runs
         if (state_r == mcds_pkg::MCDS_CAL) begin
            rank_status <= rank_stage_in;
         end
         // Final word once calibration ends
         post_status[mcds_pkg::POST_FAIL_BIT] <= (state_r == mcds_pkg::MCDS_FAIL);
         post_status[1] <= (state_r == mcds_pkg::MCDS_DONE);
         post_status[8:2] <= 7'h00;
      end
   end

   // Optional extended probe, tied to zero when not generated
   if (DEBUG_EXT) begin : g_dbg
      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            dbg_state <= 3'h0;
         end else begin
            dbg_state <= 3'(state_r);
         end
      end
   end else begin : g_nodbg
      always_ff @(posedge mclk) begin
         dbg_state <= 3'h0;
      end
   end

   // Read mux for the debug host; all words are read-only
   logic [15:0] rd_mux;
   logic [2:0]  mr_num;
   always_comb begin
      rd_mux = mcds_pkg::RESERVED_VAL;
      mr_num = 3'((dbg_addr - mcds_pkg::IDX_MR_BASE) >> 1);
      if (dbg_addr <= mcds_pkg::IDX_CFG_LAST) begin
         rd_mux = mcds_pkg::RESERVED_VAL;
      end else if (dbg_addr < mcds_pkg::IDX_CODE_NAME) begin
         if (dbg_addr[0] == mcds_pkg::IDX_MR_BASE[0]) begin
            rd_mux = {7'h00, mr_shadow_r[mr_num][8:0]};
         end else begin
            rd_mux = {9'h000, mr_shadow_r[mr_num][15:9]};
         end
      end else begin
         case (dbg_addr)
            mcds_pkg::IDX_CODE_NAME:   rd_mux = mcds_pkg::RESERVED_VAL;
            mcds_pkg::IDX_PERIOD_LO:   rd_mux = {7'h00, CLK_PERIOD[8:0]};
            mcds_pkg::IDX_PERIOD_HI:   rd_mux = {8'h00, CLK_PERIOD[16:9]};
            mcds_pkg::IDX_MOD_TYPE:    rd_mux = {8'h00, MODULE_TYPE};
            mcds_pkg::IDX_VOLTAGE:     rd_mux = {8'h00, VOLTAGE};
            mcds_pkg::IDX_MEM_FAMILY:  rd_mux = {8'h00, MEM_FAMILY};
            mcds_pkg::IDX_PLL_MULT:    rd_mux = PLL_MULT;
            mcds_pkg::IDX_PLL_DIV:     rd_mux = PLL_DIV;
            mcds_pkg::IDX_CM_MULT:     rd_mux = CM_MULT;
            mcds_pkg::IDX_CM_DIV:      rd_mux = CM_DIV;
            mcds_pkg::IDX_CTRL_INFO:   rd_mux = mcds_pkg::RESERVED_VAL;
            mcds_pkg::IDX_PRE_STATUS:  rd_mux = {7'h00, pre_status};
            mcds_pkg::IDX_POST_STATUS: rd_mux = {7'h00, post_status};
            mcds_pkg::IDX_DONE:        rd_mux = {15'h0000, calib_done};
            default:                   rd_mux = mcds_pkg::RESERVED_VAL;
         endcase
      end
   end

   // Read answer one cycle after the strobe; writes are acknowledged and dropped
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         dbg_rdata <= mcds_pkg::RD_RESET;
         dbg_ack   <= 1'b0;
      end else begin
         dbg_ack <= dbg_rd | dbg_wr; // Writes change nothing
         if (dbg_rd) begin
            dbg_rdata <= rd_mux; // Any state, any time
         end
      end
   end

   // Write data is deliberately unused: the bank has no writable word
   logic unused_wdata;
   assign unused_wdata = ^dbg_wdata;
endmodule : mcds_status
`default_nettype wire

// ---- testbench/mcds_status_props.sv ----
// Port checker for the calibration debug status bank, bound to its top
`timescale 1ns/1ps
`default_nettype none
module mcds_status_chk #(
   parameter int NUM_RANKS = 1
) (
   // Clock and reset
   input wire logic                     mclk,
   input wire logic                     rst_b,
   // Sequencer and status
   input wire logic                     mrs_valid,
   input wire logic [2:0]               mrs_sel,
   input wire logic                     cal_start,
   input wire logic                     calib_done,
   input wire logic [8:0]               post_status,
   input wire logic [NUM_RANKS*128-1:0] rank_status,
   // Debug host port
   input wire logic                     dbg_rd,
   input wire logic                     dbg_wr,
   input wire logic [15:0]              dbg_rdata,
   input wire logic                     dbg_ack
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   rd_ack_a: assert property ((dbg_rd || dbg_wr) |=> dbg_ack)
      else $error("access not acknowledged next cycle");
   idle_ack_a: assert property ((!dbg_rd && !dbg_wr) |=> !dbg_ack)
      else $error("acknowledge without access");
   rdata_hold_a: assert property ((!dbg_rd && !dbg_wr) |=> $stable(dbg_rdata))
      else $error("read data moved without a read");
   done_terminal_a: assert property (calib_done |=> calib_done)
      else $error("done flag dropped");
   done_clean_a: assert property (calib_done |-> !post_status[mcds_pkg::POST_FAIL_BIT])
      else $error("done flag high with failure");
   init_no_fail_a: assert property (mrs_valid |-> !post_status[0] && !calib_done)
      else $error("failure or done shown during init");
   mrs_gap_a: assert property (mrs_valid |=> !mrs_valid [*3])
      else $error("mode commands too close");
   mrs_order_a: assert property (mrs_valid && mrs_sel != 3'h0 |-> $past(mrs_sel, 4) == 3'(mrs_sel - 3'h1))
      else $error("mode commands out of order");
   rank_frozen_a: assert property (calib_done |=> $stable(rank_status))
      else $error("rank status moved after calibration");
   start_clean_a: assert property (cal_start |-> !calib_done && post_status == 9'h000)
      else $error("status not clean at calibration start");
endmodule : mcds_status_chk
bind mcds_status mcds_status_chk #(.NUM_RANKS(NUM_RANKS)) chk_u (.mclk(mclk), .rst_b(rst_b),
   .mrs_valid(mrs_valid), .mrs_sel(mrs_sel), .cal_start(cal_start), .calib_done(calib_done),
   .post_status(post_status), .rank_status(rank_status), .dbg_rd(dbg_rd), .dbg_wr(dbg_wr),
   .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack));
`default_nettype wire

// ---- testbench/test_memory_cal_debug_status.sv ----
// Self-checking bench for the calibration debug status bank
`timescale 1ns/1ps
`default_nettype none
module test_memory_cal_debug_status;
   // Mode values with both halves non-zero, period with its top bit set
   localparam logic [15:0] MRV [7] = '{16'hfe01, 16'h81a2, 16'h7f43, 16'h0284,
                                      16'hc305, 16'h3c86, 16'hb507};
   localparam logic [16:0] CPER     = 17'h1a5c3;
   localparam logic [5:0]  RSV [5]  = '{6'h00, 6'h0a, 6'h20, 6'h2f, 6'h39};
   localparam logic [255:0] PAT     = {128'h0123456789abcdeffedcba9876543210, 128'h5a5aa5a5c3c3};
   // Stimulus
   logic         mclk, rst_b, cal_pass, cal_fail, dbg_rd, dbg_wr;
   logic [255:0] rank_stage_in;
   logic [5:0]   dbg_addr;
   logic [15:0]  dbg_wdata;
   // Observed outputs
   logic         mrs_valid, cal_start, calib_done, dbg_ack;
   logic [2:0]   mrs_sel, dbg_state;
   logic [15:0]  mrs_value, dbg_rdata;
   logic [8:0]   pre_status, post_status;
   logic [255:0] rank_status;
   int           errors, compares, cyc, k;
   // Two ranks so each rank bus is seen separately
   mcds_status #(.NUM_RANKS(2), .DEBUG_EXT(1'b1), .MR_VAL0(MRV[0]), .MR_VAL1(MRV[1]),
      .MR_VAL2(MRV[2]), .MR_VAL3(MRV[3]), .MR_VAL4(MRV[4]), .MR_VAL5(MRV[5]), .MR_VAL6(MRV[6]),
      .CLK_PERIOD(CPER), .MODULE_TYPE(mcds_pkg::MOD_SODIMM), .VOLTAGE(mcds_pkg::VOLT_1V35),
      .MEM_FAMILY(mcds_pkg::FAM_DDR3), .PLL_MULT(16'h000a), .PLL_DIV(16'h0002),
      .CM_MULT(16'h0010), .CM_DIV(16'h0003)) dut_u (.mclk(mclk), .rst_b(rst_b),
      .cal_pass(cal_pass), .cal_fail(cal_fail), .rank_stage_in(rank_stage_in),
      .mrs_valid(mrs_valid), .mrs_sel(mrs_sel), .mrs_value(mrs_value), .cal_start(cal_start),
      .calib_done(calib_done), .pre_status(pre_status), .post_status(post_status),
      .rank_status(rank_status), .dbg_state(dbg_state), .dbg_rd(dbg_rd), .dbg_wr(dbg_wr),
      .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_ack(dbg_ack));
   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Hang guard: a full run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   // Inputs always change 1 ns after the rising edge
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask : tick
   // One read, then an idle cycle so the strobe is never reassigned at once
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      dbg_rd   = 1'b1;
      dbg_addr = a;
      tick();
      dbg_rd = 1'b0;
      chk(dbg_ack, 1'b1);
      chk(dbg_rdata, exp);
      tick();
   endtask : rd
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (4) tick();
      rst_b = 1'b1;
   endtask : do_reset
   // Init with the engine crying failure, then a clean pass
   task automatic t_init();
      cal_fail      = 1'b1;
      rank_stage_in = PAT;
      k             = 0;
      for (int i = 0; i < 400 && cal_start !== 1'b1; i++) begin
         tick();
         chk(post_status[0] | calib_done, 1'b0);
         if (mrs_valid === 1'b1) begin
            chk(mrs_sel, k[2:0]);
            chk(mrs_value, MRV[k]);
            k++;
            // Drop the false failure well before calibration samples it
            if (k == 7) cal_fail = 1'b0;
         end
      end
      chk(k, 7);
      chk(cal_start, 1'b1);
      repeat (5) tick();
      chk(pre_status[1:0], 2'b11);
      chk(calib_done, 1'b0);
      cal_pass = 1'b1;
      for (int i = 0; i < 50 && calib_done !== 1'b1; i++) tick();
      chk(calib_done, 1'b1);
      tick();
      chk(post_status[1:0], 2'b10);
      chk(rank_status, PAT);
      rank_stage_in = ~PAT;
      repeat (3) tick();
      chk(rank_status, PAT);
      $display("t_init finished");
   endtask : t_init
   // Every mapped word except the status and done words, five reserved ones and an unmapped index
   task automatic t_regs();
      for (int n = 0; n < 7; n++) begin
         rd(6'h21 + 6'(2 * n), {7'h00, MRV[n][8:0]});
         rd(6'h22 + 6'(2 * n), {9'h000, MRV[n][15:9]});
      end
      rd(6'h30, {7'h00, CPER[8:0]});
      rd(6'h31, {8'h00, CPER[16:9]});
      rd(6'h32, {8'h00, mcds_pkg::MOD_SODIMM});
      rd(6'h33, {8'h00, mcds_pkg::VOLT_1V35});
      rd(6'h34, {8'h00, mcds_pkg::FAM_DDR3});
      rd(6'h35, 16'h000a);
      rd(6'h36, 16'h0002);
      rd(6'h37, 16'h0010);
      rd(6'h38, 16'h0003);
      for (int i = 0; i < 5; i++) rd(RSV[i], mcds_pkg::RESERVED_VAL);
      rd(6'h3f, 16'h0000);
      $display("t_regs finished");
   endtask : t_regs
   // A write is acknowledged but changes nothing
   task automatic t_write();
      dbg_wr    = 1'b1;
      dbg_addr  = 6'h21;
      dbg_wdata = 16'hffff;
      tick();
      dbg_wr = 1'b0;
      chk(dbg_ack, 1'b1);
      tick();
      rd(6'h21, {7'h00, MRV[0][8:0]});
      $display("t_write finished");
   endtask : t_write
   // Second reset mid-run, then failure and pass together: failure wins
   task automatic t_fail();
      cal_pass = 1'b0;
      do_reset();
      for (int i = 0; i < 400 && cal_start !== 1'b1; i++) tick();
      cal_fail = 1'b1;
      cal_pass = 1'b1;
      repeat (10) tick();
      chk(calib_done, 1'b0);
      chk(post_status[1:0], 2'b01);
      chk(dbg_state != 3'h0, 1'b1);
      $display("t_fail finished");
   endtask : t_fail
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      {rst_b, cal_pass, cal_fail, dbg_rd, dbg_wr} = 5'h00;
      {dbg_addr, dbg_wdata, rank_stage_in} = '0;
      {errors, compares, cyc} = '0;
      tick();
      do_reset();
      t_init();
      t_regs();
      t_write();
      t_fail();
      report_and_stop();
   end
endmodule : test_memory_cal_debug_status
`default_nettype wire
